/* File: logic/timer8_pkg.sv */
// shared constants for the 8-bit timer with two compare channels
package timer8_pkg;
  localparam logic [11:0] off_control_a   = 12'h000;
  localparam logic [11:0] off_control_b   = 12'h004;
  localparam logic [11:0] off_control_c   = 12'h008;
  localparam logic [11:0] off_counter     = 12'h00C;
  localparam logic [11:0] off_compare_a   = 12'h010;
  localparam logic [11:0] off_compare_b   = 12'h014;
  localparam logic [11:0] off_flags       = 12'h018;
  localparam logic [11:0] off_int_enable  = 12'h01C;
  localparam logic [11:0] off_port        = 12'h020;
  localparam int          wave_a_lo       = 0;
  localparam int          action_b_lo     = 4;
  localparam int          action_a_lo     = 6;
  localparam int          wave_b2_bit     = 3;
  localparam int          force_b_bit     = 0;
  localparam int          force_a_bit     = 1;
  localparam int          flag_wrap_bit   = 0;
  localparam int          flag_a_bit      = 1;
  localparam int          flag_b_bit      = 2;
  localparam logic [7:0]  count_max       = 8'hFF;
  localparam logic [7:0]  count_bottom    = 8'h00;
  localparam logic [7:0]  count_one       = 8'h01;
  localparam logic [2:0]  src_stopped     = 3'h0;
  localparam logic [2:0]  src_div1        = 3'h1;
  localparam logic [2:0]  src_div8        = 3'h2;
  localparam logic [2:0]  src_div64       = 3'h3;
  localparam logic [2:0]  src_div256      = 3'h4;
  localparam logic [2:0]  src_div1024     = 3'h5;
  localparam logic [2:0]  src_ext_fall    = 3'h6;
  localparam logic [9:0]  pre_mask8       = 10'h007;
  localparam logic [9:0]  pre_mask64      = 10'h03F;
  localparam logic [9:0]  pre_mask256     = 10'h0FF;
  localparam logic [9:0]  pre_mask1024    = 10'h3FF;
  localparam logic [9:0]  pre_one         = 10'h001;
  localparam logic [1:0]  act_none        = 2'h0;
  localparam logic [1:0]  act_toggle      = 2'h1;
  localparam logic [1:0]  act_clear       = 2'h2;
  localparam logic [1:0]  act_set         = 2'h3;
  localparam logic [2:0]  wm_normal       = 3'h0;
  localparam logic [2:0]  wm_phase_max    = 3'h1;
  localparam logic [2:0]  wm_ctc          = 3'h2;
  localparam logic [2:0]  wm_fast_max     = 3'h3;
  localparam logic [2:0]  wm_phase_ocra   = 3'h5;
  localparam logic [2:0]  wm_fast_ocra    = 3'h7;
endpackage

/* File: logic/compare_chan_if.sv */
// per-channel signals between the counter core and a compare channel
interface compare_chan_if;
  logic [7:0] count;
  logic [7:0] compare;
  logic       tick;
  logic       block;
  logic       match;
  modport core (output count, output tick, output block, input compare, input match);
  modport chan (input count, input tick, input block, output compare, output match);
endinterface

/* File: logic/compare_chan.sv */
// one compare channel: buffered compare value and its match detector
module compare_chan (
  input  wire logic       pclk,
  input  wire logic       presetn,
  compare_chan_if.chan    cif,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       buffered,
  input  wire logic       load_now,
  output logic      [7:0] buffer_value
);
  logic [7:0] active_q;
  logic [7:0] buffer_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_q <= 8'h00;
    end else if (wr_en) begin
      buffer_q <= wr_data;
    end
  end

  // buffered modes move the value only at top, so pulses stay whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 8'h00;
    end else if (!buffered && wr_en) begin
      active_q <= wr_data;
    end else if (buffered && load_now) begin
      active_q <= buffer_q;
    end
  end

  assign cif.compare   = active_q;
  assign cif.match     = (cif.count == active_q) && !cif.block;
  assign buffer_value  = buffered ? buffer_q : active_q;
endmodule

/* File: logic/timer8_counter_compare_output.sv */
// 8-bit timer/counter with two compare channels behind an apb slave
// Contract
// - tick source code zero gives no tick; the counter holds
// - software reads and writes the counter at any time
// - a counter write beats clear, increment and decrement
// - each tick steps the count by one up or down, or clears it
// - top raised at the top value, bottom raised at zero
// - mode uses two bits of control a and one of control b
// - wrap flag set at mode-dependent points; interrupt source
// - two comparators match counter against compare a and b
// - match sets its flag one tick later; enabled flag requests interrupt
// - flag clears on service or by writing one to it
// - pulse-width modes load compare from buffer at top only, in fast and phase correct alike
// - normal and ctc modes write compare registers directly
// - force strobe acts like a match on output only, non-pwm
// - counter write blocks matches in the next tick, even stopped
// - output state bits survive waveform mode changes
// - output action unbuffered; force applies it at once
// - reset clears output state bits
// - nonzero action mode overrides port data; direction still gates
// - action zero leaves output state on matches
// - max is ff, bottom zero, top is max or compare a
// - mode two clears counter on compare a match
module timer8_counter_compare_output (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_pin,
  input  wire logic        ack_a,
  input  wire logic        ack_b,
  input  wire logic        ack_wrap,
  output logic             irq_a,
  output logic             irq_b,
  output logic             irq_wrap,
  output logic             pin_a_out,
  output logic             pin_a_oe_n,
  output logic             pin_b_out,
  output logic             pin_b_oe_n
);
  typedef enum logic [1:0] {dir_up_type_s = 2'b00, dir_down_type_s = 2'b01} dir_type;

  logic [7:0]  control_a_q;
  logic [7:0]  control_b_q;
  logic [7:0]  counter_q;
  logic [2:0]  flags_q;
  logic [2:0]  int_enable_q;
  logic [3:0]  port_q;
  logic [9:0]  pre_q;
  logic        ext_q;
  logic        ext_edge_q;
  logic        block_q;
  logic        wave_a_q;
  logic        wave_b_q;
  dir_type     dir_q;
  logic        tick;
  logic        wr;
  logic        rd;
  logic        wr_counter;
  logic        wr_force;
  logic [2:0]  mode;
  logic [2:0]  src;
  logic        pwm;
  logic        phase;
  logic        fast;
  logic [7:0]  top_value;
  logic        at_top;
  logic        at_bottom;
  logic        ctc_clear;
  logic        match_a;
  logic        match_b;
  logic [7:0]  buf_a;
  logic [7:0]  buf_b;
  logic [1:0]  act_a;
  logic [1:0]  act_b;
  logic        wrap_set;
  logic        load_now;
  logic [2:0]  hw_set;
  logic [2:0]  sw_clear;
  logic [2:0]  acks;

  compare_chan_if cif_a ();
  compare_chan_if cif_b ();

  assign wr         = psel && penable && pwrite;
  assign rd         = psel && !pwrite;
  assign wr_counter = wr && (paddr == timer8_pkg::off_counter);
  assign wr_force   = wr && (paddr == timer8_pkg::off_control_c) && !pwm;
  assign pready     = 1'b1;
  assign pslverr    = 1'b0;

  // mode field spans control a and control b
  assign mode  = {control_b_q[timer8_pkg::wave_b2_bit],
                  control_a_q[timer8_pkg::wave_a_lo+1 -: 2]};
  assign src   = control_b_q[2:0];
  assign act_a = control_a_q[timer8_pkg::action_a_lo+1 -: 2];
  assign act_b = control_a_q[timer8_pkg::action_b_lo+1 -: 2];
  assign phase = (mode == timer8_pkg::wm_phase_max) || (mode == timer8_pkg::wm_phase_ocra);
  assign fast  = (mode == timer8_pkg::wm_fast_max) || (mode == timer8_pkg::wm_fast_ocra);
  assign pwm   = phase || fast;

  assign top_value = (mode == timer8_pkg::wm_phase_ocra || mode == timer8_pkg::wm_fast_ocra
                      || mode == timer8_pkg::wm_ctc) ? cif_a.compare
                                                     : timer8_pkg::count_max;
  assign at_top    = (counter_q == top_value);
  assign at_bottom = (counter_q == timer8_pkg::count_bottom);
  assign ctc_clear = (mode == timer8_pkg::wm_ctc) && match_a;

  // prescaler runs free; stopping the source freezes only the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + timer8_pkg::pre_one;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q      <= 1'b0;
      ext_edge_q <= 1'b0;
    end else begin
      ext_q      <= ext_count_pin;
      ext_edge_q <= ext_q;
    end
  end

  always_comb begin
    if (src == timer8_pkg::src_stopped) begin
      tick = 1'b0;
    end else if (src == timer8_pkg::src_div1) begin
      tick = 1'b1;
    end else if (src == timer8_pkg::src_div8) begin
      tick = (pre_q & timer8_pkg::pre_mask8) == timer8_pkg::pre_mask8;
    end else if (src == timer8_pkg::src_div64) begin
      tick = (pre_q & timer8_pkg::pre_mask64) == timer8_pkg::pre_mask64;
    end else if (src == timer8_pkg::src_div256) begin
      tick = (pre_q & timer8_pkg::pre_mask256) == timer8_pkg::pre_mask256;
    end else if (src == timer8_pkg::src_div1024) begin
      tick = pre_q == timer8_pkg::pre_mask1024;
    end else if (src == timer8_pkg::src_ext_fall) begin
      tick = ext_edge_q && !ext_q;
    end else begin
      tick = ext_q && !ext_edge_q;
    end
  end

  // direction only turns in the phase correct modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= dir_up_type_s;
    end else if (!phase) begin
      dir_q <= dir_up_type_s;
    end else if (tick && at_top) begin
      dir_q <= dir_down_type_s;
    end else if (tick && at_bottom) begin
      dir_q <= dir_up_type_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_q <= 8'h00;
    end else if (wr_counter) begin
      counter_q <= pwdata[7:0];
    end else if (tick) begin
      if (ctc_clear || (fast && at_top)) begin
        counter_q <= timer8_pkg::count_bottom;
      end else if (phase && ((dir_q == dir_down_type_s && !at_bottom) || at_top)) begin
        counter_q <= counter_q - timer8_pkg::count_one;
      end else begin
        counter_q <= counter_q + timer8_pkg::count_one;
      end
    end
  end

  // a write arms the block; it covers the next tick and then lapses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_q <= 1'b0;
    end else if (wr_counter) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  assign cif_a.count = counter_q;
  assign cif_a.tick  = tick;
  assign cif_a.block = block_q;
  assign cif_b.count = counter_q;
  assign cif_b.tick  = tick;
  assign cif_b.block = block_q;
  assign match_a     = cif_a.match;
  assign match_b     = cif_b.match;
  assign load_now    = tick && (fast ? at_top : (phase && at_top));

  compare_chan u_chan_a (
    .pclk         (pclk),
    .presetn      (presetn),
    .cif          (cif_a),
    .wr_en        (wr && (paddr == timer8_pkg::off_compare_a)),
    .wr_data      (pwdata[7:0]),
    .buffered     (pwm),
    .load_now     (load_now),
    .buffer_value (buf_a)
  );

  compare_chan u_chan_b (
    .pclk         (pclk),
    .presetn      (presetn),
    .cif          (cif_b),
    .wr_en        (wr && (paddr == timer8_pkg::off_compare_b)),
    .wr_data      (pwdata[7:0]),
    .buffered     (pwm),
    .load_now     (load_now),
    .buffer_value (buf_b)
  );

  // wrap at max to zero in normal and ctc, at top in fast, at bottom in phase
  assign wrap_set = tick && (fast ? at_top
                   : phase ? (at_bottom && dir_q == dir_down_type_s)
                   : (counter_q == timer8_pkg::count_max) && !ctc_clear);

  assign hw_set   = {tick && match_b, tick && match_a, wrap_set};
  assign sw_clear = (wr && paddr == timer8_pkg::off_flags) ? pwdata[2:0] : 3'h0;
  assign acks     = {ack_b, ack_a, ack_wrap};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= hw_set | (flags_q & ~(sw_clear | acks));
    end
  end

  assign irq_wrap = flags_q[timer8_pkg::flag_wrap_bit] && int_enable_q[timer8_pkg::flag_wrap_bit];
  assign irq_a    = flags_q[timer8_pkg::flag_a_bit] && int_enable_q[timer8_pkg::flag_a_bit];
  assign irq_b    = flags_q[timer8_pkg::flag_b_bit] && int_enable_q[timer8_pkg::flag_b_bit];

  function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                     input logic pwm_mode, input logic at_bot);
    if (act == timer8_pkg::act_none) begin
      wave_next = cur;
    end else if (!pwm_mode) begin
      wave_next = (act == timer8_pkg::act_toggle) ? !cur : (act == timer8_pkg::act_set);
    end else if (act == timer8_pkg::act_toggle) begin
      wave_next = !cur;
    end else begin
      wave_next = at_bot ? (act == timer8_pkg::act_clear) : (act == timer8_pkg::act_set);
    end
  endfunction

  // output state is never touched by a mode change, only by events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_a_q <= 1'b0;
    end else if (wr_force && pwdata[timer8_pkg::force_a_bit]) begin
      wave_a_q <= wave_next(wave_a_q, act_a, 1'b0, 1'b0);
    end else if (tick && match_a) begin
      wave_a_q <= wave_next(wave_a_q, act_a, pwm, 1'b0);
    end else if (tick && fast && at_top && act_a[1]) begin
      wave_a_q <= wave_next(wave_a_q, act_a, 1'b1, 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_b_q <= 1'b0;
    end else if (wr_force && pwdata[timer8_pkg::force_b_bit]) begin
      wave_b_q <= wave_next(wave_b_q, act_b, 1'b0, 1'b0);
    end else if (tick && match_b) begin
      wave_b_q <= wave_next(wave_b_q, act_b, pwm, 1'b0);
    end else if (tick && fast && at_top && act_b[1]) begin
      wave_b_q <= wave_next(wave_b_q, act_b, 1'b1, 1'b1);
    end
  end

  // port bits: [0] data a, [1] direction a, [2] data b, [3] direction b
  assign pin_a_out  = (act_a != timer8_pkg::act_none) ? wave_a_q : port_q[0];
  assign pin_a_oe_n = !port_q[1];
  assign pin_b_out  = (act_b != timer8_pkg::act_none) ? wave_b_q : port_q[2];
  assign pin_b_oe_n = !port_q[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a_q  <= 8'h00;
      control_b_q  <= 8'h00;
      int_enable_q <= 3'h0;
      port_q       <= 4'h0;
    end else if (wr) begin
      if (paddr == timer8_pkg::off_control_a) begin
        control_a_q <= pwdata[7:0];
      end else if (paddr == timer8_pkg::off_control_b) begin
        control_b_q <= pwdata[7:0] & 8'h0F;
      end else if (paddr == timer8_pkg::off_int_enable) begin
        int_enable_q <= pwdata[2:0];
      end else if (paddr == timer8_pkg::off_port) begin
        port_q <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd && !penable) begin
      if (paddr == timer8_pkg::off_control_a) begin
        prdata <= {24'h000000, control_a_q};
      end else if (paddr == timer8_pkg::off_control_b) begin
        prdata <= {24'h000000, control_b_q};
      end else if (paddr == timer8_pkg::off_counter) begin
        prdata <= {24'h000000, counter_q};
      end else if (paddr == timer8_pkg::off_compare_a) begin
        prdata <= {24'h000000, buf_a};
      end else if (paddr == timer8_pkg::off_compare_b) begin
        prdata <= {24'h000000, buf_b};
      end else if (paddr == timer8_pkg::off_flags) begin
        prdata <= {29'h00000000, flags_q};
      end else if (paddr == timer8_pkg::off_int_enable) begin
        prdata <= {29'h00000000, int_enable_q};
      end else if (paddr == timer8_pkg::off_port) begin
        prdata <= {28'h0000000, port_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule

/* File: tb/timer8_counter_compare_output_asserts.sv */
// port-level checker for the 8-bit timer with two compare channels
module timer8_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_a,
  input wire logic        pin_a_out,
  input wire logic        pin_a_oe_n,
  input wire logic        pin_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       wr;
  logic       rd;
  logic       ctla_w;
  logic       ctlb_w;
  logic       stopped;
  logic       quiet;
  logic [7:0] ctla_q;
  logic [3:0] ctlb_q;
  logic [3:0] port_q;
  logic [7:0] cnt_q;
  logic       known_q;
  assign wr      = psel && penable && pready && pwrite;
  assign rd      = psel && penable && pready && !pwrite;
  assign ctla_w  = wr && paddr == timer8_pkg::off_control_a;
  assign ctlb_w  = wr && paddr == timer8_pkg::off_control_b;
  assign stopped = ctlb_q[2:0] == timer8_pkg::src_stopped;
  assign quiet   = stopped && {ctlb_q[3], ctla_q[1:0]} == timer8_pkg::wm_normal;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctla_q <= 8'h00;
      ctlb_q <= 4'h0;
      port_q <= 4'h0;
    end else begin
      if (ctla_w)
        ctla_q <= pwdata[7:0];
      if (ctlb_w)
        ctlb_q <= pwdata[3:0];
      if (wr && paddr == timer8_pkg::off_port)
        port_q <= pwdata[3:0];
    end
  end
  // the count is only predictable when loaded with no tick source running since
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 8'h00;
      known_q <= 1'b1;
    end else if (wr && paddr == timer8_pkg::off_counter) begin
      cnt_q   <= pwdata[7:0];
      known_q <= stopped;
    end else if (ctlb_w && pwdata[2:0] != timer8_pkg::src_stopped)
      known_q <= 1'b0;
  end
  property p_ready;
    pready && !pslverr;
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer late or in error");
  property p_irq_off;
    wr && paddr == timer8_pkg::off_int_enable && !pwdata[timer8_pkg::flag_a_bit] |=> !irq_a [*2];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked channel a still requests");
  property p_oe_a;
    wr && paddr == timer8_pkg::off_port |=> pin_a_oe_n == !$past(pwdata[1]);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a drive enable wrong");
  property p_port_a;
    ctla_q[7:6] == timer8_pkg::act_none |-> pin_a_out == port_q[0];
  endproperty
  a_port_a: assert property (p_port_a) else $error("pin a not port data");
  property p_frozen;
    rd && paddr == timer8_pkg::off_counter && known_q |-> prdata[7:0] == cnt_q;
  endproperty
  a_frozen: assert property (p_frozen) else $error("stopped count moved");
  property p_force_set_a;
    wr && paddr == timer8_pkg::off_control_c && pwdata[timer8_pkg::force_a_bit] && quiet
      && ctla_q[7:6] == timer8_pkg::act_set |=> pin_a_out;
  endproperty
  a_force_set_a: assert property (p_force_set_a) else $error("force did not set a");
  property p_force_tog_a;
    wr && paddr == timer8_pkg::off_control_c && pwdata[timer8_pkg::force_a_bit] && quiet
      && ctla_q[7:6] == timer8_pkg::act_toggle |=> pin_a_out != $past(pin_a_out);
  endproperty
  a_force_tog_a: assert property (p_force_tog_a) else $error("force did not toggle a");
  property p_force_clr_b;
    wr && paddr == timer8_pkg::off_control_c && pwdata[timer8_pkg::force_b_bit] && quiet
      && ctla_q[5:4] == timer8_pkg::act_clear |=> !pin_b_out;
  endproperty
  a_force_clr_b: assert property (p_force_clr_b) else $error("force did not clear b");
  property p_mode_keep;
    ctla_w && stopped && pwdata[7:6] == ctla_q[7:6] && ctla_q[7:6] != timer8_pkg::act_none
      |=> $stable(pin_a_out);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode change moved pin a");
  property p_reset;
    $rose(presetn) |-> !pin_a_out && pin_a_oe_n;
  endproperty
  a_reset: assert property (p_reset) else $error("pin a not idle after reset");
  c_force: cover property (wr && paddr == timer8_pkg::off_control_c && quiet);
  c_frozen: cover property (rd && paddr == timer8_pkg::off_counter && known_q);
  c_port: cover property (wr && paddr == timer8_pkg::off_port);
endmodule

bind timer8_counter_compare_output timer8_checker i_timer8_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_a, .pin_a_out,
  .pin_a_oe_n, .pin_b_out);

/* File: tb/timer8_counter_compare_output_bench.sv */
// self-checking bench for the 8-bit timer with two compare channels
module timer8_counter_compare_output_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk          = 1'b0;
  logic        presetn       = 1'b0;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [11:0] paddr         = 12'h000;
  logic [31:0] pwdata        = 32'h00000000;
  logic        ext_count_pin = 1'b0;
  logic        ack_a         = 1'b0;
  logic        ack_b         = 1'b0;
  logic        ack_wrap      = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_a;
  logic        irq_b;
  logic        irq_wrap;
  logic        pin_a_out;
  logic        pin_a_oe_n;
  logic        pin_b_out;
  logic        pin_b_oe_n;
  logic [31:0] rv;
  logic [7:0]  hold;
  int          mismatches    = 0;
  int          n_checks      = 0;
  int          div [4]       = '{8, 64, 256, 1024};
  always #4 pclk = ~pclk;
  timer8_counter_compare_output i_timer8_counter_compare_output (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_count_pin, .ack_a,
    .ack_b, .ack_wrap, .irq_a, .irq_b, .irq_wrap, .pin_a_out, .pin_a_oe_n, .pin_b_out,
    .pin_b_oe_n);
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic verify(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // the request stands until pready is seen high, never assumed
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    verify(pready === 1'b1, "no ready");
    rv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    verify(rv === e, "register read");
  endtask
  // pins are combinational from registers, so look after the edge has settled
  task automatic pins(input logic [3:0] e);
    @(negedge pclk);
    verify({pin_b_oe_n, pin_b_out, pin_a_oe_n, pin_a_out} === e, "pin state");
  endtask
  task automatic run(input logic [2:0] src, input int cycles);
    wr(timer8_pkg::off_control_b, {29'h0, src});
    repeat (cycles) @(posedge pclk);
    wr(timer8_pkg::off_control_b, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    pins(4'hA);
    chk(timer8_pkg::off_counter, 32'h0);
    wr(12'hFFC, 32'hFFFFFFFF);
    chk(12'hFFC, 32'h0);
    wr(timer8_pkg::off_counter, 32'h5A);
    repeat (20) @(posedge pclk);
    chk(timer8_pkg::off_counter, 32'h5A);
    // back-to-back reads capture three clocks apart
    wr(timer8_pkg::off_control_b, {29'h0, timer8_pkg::src_div1});
    bus(1'b0, timer8_pkg::off_counter, 32'h0);
    hold = rv[7:0];
    chk(timer8_pkg::off_counter, {24'h0, hold + 8'h03});
    wr(timer8_pkg::off_counter, 32'h80);
    chk(timer8_pkg::off_counter, 32'h81);
    wr(timer8_pkg::off_control_b, 32'h0);
    wr(timer8_pkg::off_control_a, {29'h0, timer8_pkg::wm_ctc});
    wr(timer8_pkg::off_compare_a, 32'h05);
    wr(timer8_pkg::off_counter, 32'h00);
    wr(timer8_pkg::off_flags, 32'h07);
    wr(timer8_pkg::off_int_enable, 32'h02);
    run(timer8_pkg::src_div1, 40);
    bus(1'b0, timer8_pkg::off_counter, 32'h0);
    verify(rv[7:0] <= 8'h05, "count passed compare a");
    chk(timer8_pkg::off_flags, 32'h06);
    verify(irq_a === 1'b1 && irq_b === 1'b0, "irq a");
    wr(timer8_pkg::off_flags, 32'h02);
    chk(timer8_pkg::off_flags, 32'h04);
    verify(irq_a === 1'b0, "irq a after clear");
    @(posedge pclk);
    ack_b <= 1'b1;
    @(posedge pclk);
    ack_b <= 1'b0;
    chk(timer8_pkg::off_flags, 32'h00);
    wr(timer8_pkg::off_control_a, 32'h00);
    wr(timer8_pkg::off_counter, 32'hFD);
    wr(timer8_pkg::off_int_enable, 32'h01);
    run(timer8_pkg::src_div1, 8);
    bus(1'b0, timer8_pkg::off_flags, 32'h0);
    verify(rv[0] === 1'b1 && irq_wrap === 1'b1, "wrap flag");
    @(posedge pclk);
    ack_wrap <= 1'b1;
    @(posedge pclk);
    ack_wrap <= 1'b0;
    bus(1'b0, timer8_pkg::off_flags, 32'h0);
    verify(rv[0] === 1'b0 && irq_wrap === 1'b0, "wrap flag serviced");
    wr(timer8_pkg::off_compare_b, 32'h30);
    wr(timer8_pkg::off_counter, 32'h30);
    wr(timer8_pkg::off_flags, 32'h07);
    run(timer8_pkg::src_div1, 4);
    bus(1'b0, timer8_pkg::off_flags, 32'h0);
    verify(rv[2] === 1'b0, "match after load");
    wr(timer8_pkg::off_counter, 32'h2E);
    run(timer8_pkg::src_div1, 4);
    bus(1'b0, timer8_pkg::off_flags, 32'h0);
    verify(rv[2] === 1'b1, "match b missing");
    wr(timer8_pkg::off_compare_a, 32'h20);
    chk(timer8_pkg::off_compare_a, 32'h20);
    wr(timer8_pkg::off_control_a, {29'h0, timer8_pkg::wm_fast_max});
    wr(timer8_pkg::off_compare_a, 32'h80);
    chk(timer8_pkg::off_compare_a, 32'h80);
    wr(timer8_pkg::off_counter, 32'h10);
    wr(timer8_pkg::off_flags, 32'h07);
    run(timer8_pkg::src_div1, 24);
    bus(1'b0, timer8_pkg::off_flags, 32'h0);
    verify(rv[1] === 1'b1, "buffered compare applied early");
    // phase correct: fe, ff, then turns down to f9 in seven ticks
    wr(timer8_pkg::off_control_a, {29'h0, timer8_pkg::wm_phase_max});
    wr(timer8_pkg::off_counter, 32'hFE);
    run(timer8_pkg::src_div1, 4);
    chk(timer8_pkg::off_counter, 32'hF9);
    wr(timer8_pkg::off_control_a, 32'h00);
    chk(timer8_pkg::off_compare_a, 32'h80);
    // prescaler phase is free running, so allow one tick of slack
    foreach (div[i]) begin
      wr(timer8_pkg::off_counter, 32'h0);
      run(3'(i + 2), 4 * div[i]);
      bus(1'b0, timer8_pkg::off_counter, 32'h0);
      verify(rv[7:0] >= 8'h03 && rv[7:0] <= 8'h05, "prescaled count");
    end
    for (int c = 6; c < 8; c++) begin
      wr(timer8_pkg::off_counter, 32'h0);
      wr(timer8_pkg::off_control_b, 32'(c));
      repeat (10) begin
        repeat (4) @(posedge pclk);
        ext_count_pin <= ~ext_count_pin;
      end
      repeat (6) @(posedge pclk);
      wr(timer8_pkg::off_control_b, 32'h0);
      chk(timer8_pkg::off_counter, 32'h05);
    end
    wr(timer8_pkg::off_port, 32'h0);
    wr(timer8_pkg::off_control_a, 32'hE0);
    wr(timer8_pkg::off_flags, 32'h07);
    bus(1'b0, timer8_pkg::off_counter, 32'h0);
    hold = rv[7:0];
    wr(timer8_pkg::off_control_c, 32'h03);
    pins(4'hB);
    wr(timer8_pkg::off_port, 32'h0A);
    pins(4'h1);
    chk(timer8_pkg::off_flags, 32'h00);
    chk(timer8_pkg::off_counter, {24'h0, hold});
    wr(timer8_pkg::off_control_a, 32'h60);
    wr(timer8_pkg::off_control_c, 32'h02);
    pins(4'h0);
    wr(timer8_pkg::off_control_a, 32'h62);
    pins(4'h0);
    wr(timer8_pkg::off_control_c, 32'h02);
    pins(4'h1);
    wr(timer8_pkg::off_control_a, 32'h63);
    wr(timer8_pkg::off_control_c, 32'h02);
    pins(4'h1);
    wr(timer8_pkg::off_control_a, 32'h00);
    pins(4'h0);
    wr(timer8_pkg::off_port, 32'h0B);
    pins(4'h1);
    conclude();
  end
endmodule
